/* inc/fan_cfg_defines.vh */
// offsets, field positions, reset values and timing counts of the fan monitor configuration bank
`ifndef FAN_CFG_DEFINES_VH
`define FAN_CFG_DEFINES_VH
`define OFS_PIN_SENSE 8'h02
`define OFS_CHAN_FLOOR 8'h03
`define OFS_FAN_A_SRC 8'h05
`define OFS_FAN_B_SRC 8'h06
`define OFS_LOW_BITS 8'h08
`define OFS_MSB_AIN_A 8'h0a
`define OFS_MSB_AIN_B 8'h0b
`define OFS_MSB_SUPPLY 8'h0c
`define OFS_MSB_DIODE 8'h0d
`define RST_PIN_SENSE 8'hc0
`define RST_CHAN_FLOOR 8'h00
`define RST_FAN_SRC 8'h0c
`define RST_LOW_BITS 8'h00
`define UNLOCKED_MASK_PIN_SENSE 8'h30
`define CHAN_FLOOR_MASK 8'h3f
`define MF_FAN_ON 2'b00
`define MF_OVERTEMP 2'b01
`define BIT_BOOST 2
`define BIT_FAST 3
`define BIT_CONT_A 4
`define BIT_CONT_B 5
`define BIT_RES_A 6
`define BIT_RES_B 7
`define BIT_ONE_CHAN 3
`define BIT_FLOOR_A 4
`define BIT_FLOOR_B 5
`define BIT_DIRECT 4
`define BIT_MINSPD 5
`define BIT_SPINUP 6
`define BIT_MAXSPD 7
`define CHAN_DIODE_ONE 3'b011
`define CHAN_ONCHIP 3'b100
`define CHAN_DIODE_TWO 3'b101
`define FULL_DUTY 8'hff
`define CLK_HZ 25000000
`define SLOW_PERIOD_MS 1000
`define FAST_PERIOD_MS 250
// sized to the 25-bit sample counter: 1 s and 250 ms at a 25 MHz clock
`define SLOW_CYCLES 25'd25000000
`define FAST_CYCLES 25'd6250000
`endif

/* src/fan_demand.v */
// per-fan drive level selection from source bits and override priority
`include "fan_cfg_defines.vh"
module fan_demand (
  // control
  input wire [7:0] src_ctrl,
  input wire input_a_resistor,
  input wire input_b_resistor,
  input wire second_diode,
  input wire floor_hold,
  input wire boost_force,
  // temperature demands
  input wire [7:0] dem_input_a,
  input wire [7:0] dem_diode_two,
  input wire [7:0] dem_input_b,
  input wire [7:0] dem_diode_one,
  input wire [7:0] dem_onchip,
  // speed settings
  input wire [7:0] direct_level,
  input wire [7:0] min_level,
  input wire [7:0] spinup_level,
  input wire [7:0] max_level,
  // result
  output reg [7:0] level
);
  function [7:0] max8;
    input [7:0] a;
    input [7:0] b;
    begin
      max8 = (a > b) ? a : b;
    end
  endfunction

  reg [7:0] auto_lvl;
  reg [7:0] first_src;
  always @* begin
    auto_lvl = 8'h00;
    // a diode on the shared pins wins over resistor mode
    first_src = (input_a_resistor && !second_diode) ? dem_input_a : dem_diode_two; // [R12] [R20]
    if (src_ctrl[0])
      auto_lvl = max8(auto_lvl, first_src); // [R11]
    if (src_ctrl[1] && input_b_resistor && !second_diode)
      auto_lvl = max8(auto_lvl, dem_input_b); // [R13]
    if (src_ctrl[2])
      auto_lvl = max8(auto_lvl, dem_diode_one); // [R13]
    if (src_ctrl[3])
      auto_lvl = max8(auto_lvl, dem_onchip); // [R11] [R13]
    if (src_ctrl[`BIT_MAXSPD])
      level = max_level; // [R15] [R21]
    else if (src_ctrl[`BIT_SPINUP])
      level = spinup_level; // [R15]
    else if (src_ctrl[`BIT_MINSPD])
      level = min_level; // [R15]
    else if (src_ctrl[`BIT_DIRECT])
      level = direct_level; // [R14]
    else
      level = auto_lvl;
    if (floor_hold && level < min_level)
      level = min_level; // [R9]
    if (boost_force)
      level = `FULL_DUTY; // [R3]
  end
endmodule

/* src/fan_monitor_config_regs.v */
// configuration register bank of the thermal monitor and dual fan controller
//
// Summary of operation
// R1: with lock set, config three ignores writes except continuous speed-sense bits 4 and 5.
// R2: pin field 00 fan-on output, 01 over-temperature output, 1x cpu-hot input.
// R3: boost set and cpu-hot asserted forces every fan to full duty.
// R4: fast bit raises speed-sense rate from once per second to every 250 ms.
// R5: bits 4 and 5 enable continuous speed sensing on inputs a and b.
// R6: bits 6 and 7 set analog inputs as resistor sensor or voltage input.
// R7: channel select 011 diode one, 100 on-chip, 101 diode two.
// R8: bit 3 of config four selects repeated single-channel measurement.
// R9: floor-hold bits keep each fan at or above its minimum speed.
// R10: config four bits 6 and 7 ignore writes and read zero.
// R11: several source bits set drive the fan at the highest demand.
// R12: source bit 0 follows resistor input a or else diode two.
// R13: bit 1 resistor input b when resistor, bit 2 diode one, bit 3 on-chip.
// R14: direct drive bit gives software the drive level, overriding source bits.
// R15: bits 5,6,7 force minimum, spin-up, maximum; higher bit overrides lower.
// R16: fan b control register applies the same selection to fan b.
// R17: low bits register holds two lsbs of diode, supply, analog b, analog a.
// R18: reading low bits freezes it and matching msb readings until those are read.
// R19: writing 1 to the lock makes lockable registers read-only until power cycle.
// R20: second-diode bit makes both analog inputs one diode, overriding resistor bits.
// R21: fan b maximum-speed override sits at bit 7 like fan a.
`include "fan_cfg_defines.vh"
module fan_monitor_config_regs (
  // clock and reset
  input wire clock,
  input wire rst_b,
  input wire clk_en,
  // register port from the serial interface
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // settings from other configuration registers
  input wire lock_set,
  input wire second_diode_cfg,
  // live readings: msbs and two low bits each
  input wire [9:0] rd_diode,
  input wire [9:0] rd_supply,
  input wire [9:0] rd_ain_a,
  input wire [9:0] rd_ain_b,
  // temperature demands per source
  input wire [7:0] dem_input_a,
  input wire [7:0] dem_diode_two,
  input wire [7:0] dem_input_b,
  input wire [7:0] dem_diode_one,
  input wire [7:0] dem_onchip,
  // speed settings
  input wire [7:0] fan_a_level,
  input wire [7:0] fan_b_level,
  input wire [7:0] min_level_a,
  input wire [7:0] min_level_b,
  input wire [7:0] spinup_level,
  input wire [7:0] max_level,
  // multifunction pin
  input wire cpu_hot_pin,
  input wire fan_a_on_src,
  input wire overtemp_src,
  output reg multipin_o,
  output reg multipin_oe,
  output reg cpu_hot_in,
  // measurement control
  output reg speed_sample,
  output reg cont_speed_meas_a,
  output reg cont_speed_meas_b,
  output reg input_a_resistor_sel,
  output reg input_b_resistor_sel,
  output reg one_channel_mode,
  output reg [2:0] chan_sel,
  output reg [2:0] meas_chan_code,
  // fan drive
  output reg [7:0] fan_a_drive,
  output reg [7:0] fan_b_drive
);
  reg [7:0] pin_sense_q;
  reg [7:0] chan_floor_q;
  reg [7:0] fan_a_src_q;
  reg [7:0] fan_b_src_q;
  reg [7:0] low_bits_q;
  reg [7:0] msb_diode_q;
  reg [7:0] msb_supply_q;
  reg [7:0] msb_ain_a_q;
  reg [7:0] msb_ain_b_q;
  reg [3:0] frozen_q;
  reg lock_q;
  reg hot_s1_q;
  reg hot_s2_q;
  reg [24:0] rate_cnt_q;
  reg [2:0] rr_chan_q;

  wire [24:0] slow_max = `SLOW_CYCLES - 25'd1;
  wire [24:0] fast_max = `FAST_CYCLES - 25'd1;
  // the freezing read itself must not refresh anything, so the low bits
  // handed out and the msbs held back come from one and the same sample;
  // otherwise the msbs would be one sample newer than the low bits
  wire freeze_now = reg_rd && (reg_addr == `OFS_LOW_BITS);
  wire mf_is_hot_in = pin_sense_q[1]; // [R2]
  wire boost_force = pin_sense_q[`BIT_BOOST] && mf_is_hot_in && !hot_s2_q; // [R3]
  wire [7:0] lvl_a;
  wire [7:0] lvl_b;

  fan_demand u_dem_a (
    .src_ctrl(fan_a_src_q),
    .input_a_resistor(pin_sense_q[`BIT_RES_A]),
    .input_b_resistor(pin_sense_q[`BIT_RES_B]),
    .second_diode(second_diode_cfg),
    .floor_hold(chan_floor_q[`BIT_FLOOR_A]),
    .boost_force(boost_force),
    .dem_input_a(dem_input_a),
    .dem_diode_two(dem_diode_two),
    .dem_input_b(dem_input_b),
    .dem_diode_one(dem_diode_one),
    .dem_onchip(dem_onchip),
    .direct_level(fan_a_level),
    .min_level(min_level_a),
    .spinup_level(spinup_level),
    .max_level(max_level),
    .level(lvl_a)
  );

  // same selection logic reused for the second fan
  fan_demand u_dem_b ( // [R16]
    .src_ctrl(fan_b_src_q),
    .input_a_resistor(pin_sense_q[`BIT_RES_A]),
    .input_b_resistor(pin_sense_q[`BIT_RES_B]),
    .second_diode(second_diode_cfg),
    .floor_hold(chan_floor_q[`BIT_FLOOR_B]),
    .boost_force(boost_force),
    .dem_input_a(dem_input_a),
    .dem_diode_two(dem_diode_two),
    .dem_input_b(dem_input_b),
    .dem_diode_one(dem_diode_one),
    .dem_onchip(dem_onchip),
    .direct_level(fan_b_level),
    .min_level(min_level_b),
    .spinup_level(spinup_level),
    .max_level(max_level),
    .level(lvl_b)
  );

  // register writes and the freeze of readings
  always @(posedge clock) begin
    if (!rst_b) begin
      pin_sense_q <= `RST_PIN_SENSE;
      chan_floor_q <= `RST_CHAN_FLOOR;
      fan_a_src_q <= `RST_FAN_SRC;
      fan_b_src_q <= `RST_FAN_SRC;
      low_bits_q <= `RST_LOW_BITS;
      msb_diode_q <= 8'h00;
      msb_supply_q <= 8'h00;
      msb_ain_a_q <= 8'h00;
      msb_ain_b_q <= 8'h00;
      frozen_q <= 4'h0;
      lock_q <= 1'b0;
    end else if (clk_en) begin
      // once seen, lock stays until power cycle; reset here stands in for power-on
      if (lock_set)
        lock_q <= 1'b1; // [R19]
      if (reg_wr) begin
        case (reg_addr)
          `OFS_PIN_SENSE: begin
            if (lock_q || lock_set)
              pin_sense_q <= (pin_sense_q & ~`UNLOCKED_MASK_PIN_SENSE) |
                             (reg_wdata & `UNLOCKED_MASK_PIN_SENSE); // [R1] [R19]
            else
              pin_sense_q <= reg_wdata;
          end
          `OFS_CHAN_FLOOR: chan_floor_q <= reg_wdata & `CHAN_FLOOR_MASK; // [R10]
          `OFS_FAN_A_SRC: fan_a_src_q <= reg_wdata;
          `OFS_FAN_B_SRC: fan_b_src_q <= reg_wdata;
          default: ;
        endcase
      end
      // live values track while unfrozen; a low-bit read freezes all four
      if (!frozen_q[0] && !freeze_now)
        msb_diode_q <= rd_diode[9:2]; // [R18]
      if (!frozen_q[1] && !freeze_now)
        msb_supply_q <= rd_supply[9:2];
      if (!frozen_q[2] && !freeze_now)
        msb_ain_b_q <= rd_ain_b[9:2];
      if (!frozen_q[3] && !freeze_now)
        msb_ain_a_q <= rd_ain_a[9:2];
      if (frozen_q == 4'h0 && !freeze_now)
        low_bits_q <= {rd_ain_a[1:0], rd_ain_b[1:0], rd_supply[1:0], rd_diode[1:0]}; // [R17]
      if (reg_rd) begin
        case (reg_addr)
          `OFS_LOW_BITS: frozen_q <= 4'hf; // [R18]
          `OFS_MSB_DIODE: frozen_q[0] <= 1'b0; // [R18]
          `OFS_MSB_SUPPLY: frozen_q[1] <= 1'b0;
          `OFS_MSB_AIN_B: frozen_q[2] <= 1'b0;
          `OFS_MSB_AIN_A: frozen_q[3] <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // read data, registered one cycle after the strobe
  always @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        `OFS_PIN_SENSE: reg_rdata <= pin_sense_q;
        `OFS_CHAN_FLOOR: reg_rdata <= chan_floor_q & `CHAN_FLOOR_MASK; // [R10]
        `OFS_FAN_A_SRC: reg_rdata <= fan_a_src_q;
        `OFS_FAN_B_SRC: reg_rdata <= fan_b_src_q;
        `OFS_LOW_BITS: reg_rdata <= low_bits_q; // [R17]
        `OFS_MSB_DIODE: reg_rdata <= msb_diode_q;
        `OFS_MSB_SUPPLY: reg_rdata <= msb_supply_q;
        `OFS_MSB_AIN_B: reg_rdata <= msb_ain_b_q;
        `OFS_MSB_AIN_A: reg_rdata <= msb_ain_a_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // cpu-hot pin is asynchronous and active low
  always @(posedge clock) begin
    if (!rst_b) begin
      hot_s1_q <= 1'b1;
      hot_s2_q <= 1'b1;
    end else if (clk_en) begin
      hot_s1_q <= cpu_hot_pin;
      hot_s2_q <= hot_s1_q;
    end
  end

  // speed-sense sample timer; a shortened period takes effect at once, wrapping next cycle if the count is already past it
  always @(posedge clock) begin
    if (!rst_b) begin
      rate_cnt_q <= 25'd0;
      speed_sample <= 1'b0;
    end else if (clk_en) begin
      speed_sample <= 1'b0;
      if (rate_cnt_q >= (pin_sense_q[`BIT_FAST] ? fast_max : slow_max)) begin // [R4]
        rate_cnt_q <= 25'd0;
        speed_sample <= 1'b1;
      end else begin
        rate_cnt_q <= rate_cnt_q + 25'd1;
      end
    end
  end

  // measurement channel sequencing: round robin over codes 0..5 or one channel
  always @(posedge clock) begin
    if (!rst_b) begin
      rr_chan_q <= 3'd0;
      meas_chan_code <= 3'd0;
    end else if (clk_en && speed_sample) begin
      rr_chan_q <= (rr_chan_q == `CHAN_DIODE_TWO) ? 3'd0 : rr_chan_q + 3'd1;
      if (chan_floor_q[`BIT_ONE_CHAN])
        meas_chan_code <= chan_floor_q[2:0]; // [R7] [R8]
      else
        meas_chan_code <= rr_chan_q;
    end
  end

  // registered outputs
  always @(posedge clock) begin
    if (!rst_b) begin
      multipin_o <= 1'b0;
      multipin_oe <= 1'b0;
      cpu_hot_in <= 1'b0;
      cont_speed_meas_a <= 1'b0;
      cont_speed_meas_b <= 1'b0;
      input_a_resistor_sel <= 1'b0;
      input_b_resistor_sel <= 1'b0;
      one_channel_mode <= 1'b0;
      chan_sel <= 3'd0;
      fan_a_drive <= 8'h00;
      fan_b_drive <= 8'h00;
    end else if (clk_en) begin
      case (pin_sense_q[1:0])
        `MF_FAN_ON: begin
          multipin_o <= fan_a_on_src; // [R2]
          multipin_oe <= 1'b1;
        end
        `MF_OVERTEMP: begin
          multipin_o <= overtemp_src; // [R2]
          multipin_oe <= 1'b1;
        end
        default: begin
          multipin_o <= 1'b0;
          multipin_oe <= 1'b0; // [R2]
        end
      endcase
      cpu_hot_in <= mf_is_hot_in && !hot_s2_q;
      cont_speed_meas_a <= pin_sense_q[`BIT_CONT_A]; // [R5]
      cont_speed_meas_b <= pin_sense_q[`BIT_CONT_B]; // [R5]
      input_a_resistor_sel <= pin_sense_q[`BIT_RES_A] && !second_diode_cfg; // [R6] [R20]
      input_b_resistor_sel <= pin_sense_q[`BIT_RES_B] && !second_diode_cfg; // [R6] [R20]
      one_channel_mode <= chan_floor_q[`BIT_ONE_CHAN]; // [R8]
      chan_sel <= chan_floor_q[2:0];
      fan_a_drive <= lvl_a;
      fan_b_drive <= lvl_b;
    end
  end
endmodule

/* bench/fan_cfg_chk.sv */
// port assertions for the fan configuration bank
module fan_cfg_chk (
  // clock and reset
  input logic clock,
  input logic rst_b,
  input logic clk_en,
  // register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic lock_set,
  input logic second_diode_cfg,
  // readings
  input logic [9:0] rd_diode,
  input logic [9:0] rd_supply,
  input logic [9:0] rd_ain_a,
  input logic [9:0] rd_ain_b,
  // pin and settings
  input logic cpu_hot_pin,
  input logic multipin_oe,
  input logic cpu_hot_in,
  input logic cont_speed_meas_a,
  input logic cont_speed_meas_b,
  input logic input_a_resistor_sel,
  input logic one_channel_mode,
  input logic [2:0] chan_sel,
  input logic [7:0] fan_a_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lk_q;
  wire rd_en = clk_en && reg_rd;
  wire w2 = clk_en && reg_wr && reg_addr == 8'h02;
  wire w3 = clk_en && reg_wr && reg_addr == 8'h03;
  wire lkd = lock_set || lk_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // the lock level may drop later, so its first sighting is remembered here
  always @(posedge clock) begin
    if (!rst_b)
      lk_q <= 1'b0;
    else if (lock_set)
      lk_q <= 1'b1;
  end
  lock_hold_a: assert property (w2 && lkd && !second_diode_cfg ##1 !reg_wr && !second_diode_cfg |->
    ##1 input_a_resistor_sel == $past(input_a_resistor_sel)) else $error("locked write changed type");
  cont_bits_a: assert property (w2 ##1 !reg_wr |->
    ##1 {cont_speed_meas_b, cont_speed_meas_a} == $past(reg_wdata[5:4], 2)) else $error("speed bits wrong");
  pin_mode_a: assert property (w2 && !lkd ##1 !reg_wr |->
    ##1 multipin_oe == !$past(reg_wdata[1], 2)) else $error("pin direction wrong");
  chan_mode_a: assert property (w3 && !lkd ##1 !reg_wr |->
    ##1 {one_channel_mode, chan_sel} == $past(reg_wdata[3:0], 2)) else $error("channel select wrong");
  rsvd_zero_a: assert property (rd_en && reg_addr == 8'h03 |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved bits not zero");
  unmapped_zero_a: assert property (rd_en && !(reg_addr inside {8'h02, 8'h03, 8'h05, 8'h06, 8'h08, [8'h0a:8'h0d]})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  hot_input_a: assert property (cpu_hot_in |-> !$past(cpu_hot_pin, 3))
    else $error("cpu hot without low pin");
  low_bits_a: assert property (rd_en && reg_addr == 8'h08 |=>
    reg_rdata == $past({rd_ain_a[1:0], rd_ain_b[1:0], rd_supply[1:0], rd_diode[1:0]}, 2)) else $error("low bits wrong");
  stall_hold_a: assert property (!clk_en |=> $stable(fan_a_drive) && $stable(reg_rdata))
    else $error("state moved while stalled");
endmodule
bind fan_monitor_config_regs fan_cfg_chk chk (.clock, .rst_b, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .lock_set, .second_diode_cfg, .rd_diode, .rd_supply, .rd_ain_a, .rd_ain_b, .cpu_hot_pin,
  .multipin_oe, .cpu_hot_in, .cont_speed_meas_a, .cont_speed_meas_b, .input_a_resistor_sel, .one_channel_mode,
  .chan_sel, .fan_a_drive);

/* bench/reading_model.sv */
// live sensor readings that move every cycle, so a missing freeze shows
module reading_model (
  // clock
  input logic clock,
  // readings
  output logic [9:0] rd_diode,
  output logic [9:0] rd_supply,
  output logic [9:0] rd_ain_a,
  output logic [9:0] rd_ain_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] n_q = 10'h000;
  always @(posedge clock) begin
    n_q <= n_q + 10'h00b;
  end
  // four different patterns so a swapped field is visible
  assign rd_diode = n_q;
  assign rd_supply = ~n_q;
  assign rd_ain_a = {n_q[4:0], n_q[9:5]};
  assign rd_ain_b = n_q ^ 10'h2a5;
endmodule

/* bench/fan_monitor_config_regs_test.sv */
// self-checking bench for the fan configuration bank
module fan_monitor_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic lock_set = 1'b0;
  logic second_diode_cfg = 1'b0;
  logic cpu_hot_pin = 1'b1;
  logic fan_a_on_src = 1'b0;
  logic overtemp_src = 1'b0;
  logic [7:0] v [11];
  logic [7:0] cs [10] = '{8'h0c, 8'h04, 8'h08, 8'h01, 8'h02, 8'h03, 8'h1f, 8'h3f, 8'h7f, 8'hff};
  logic [9:0] s [4];
  wire [7:0] reg_rdata, fan_a_drive, fan_b_drive;
  wire [9:0] rd_diode, rd_supply, rd_ain_a, rd_ain_b;
  wire multipin_o, multipin_oe, cpu_hot_in, input_a_resistor_sel, input_b_resistor_sel;
  wire cont_speed_meas_a, cont_speed_meas_b, one_channel_mode;
  wire [2:0] chan_sel;
  int err_count = 0;
  int cmp_count = 0;
  always #20 clock = ~clock;
  reading_model sensors (.clock, .rd_diode, .rd_supply, .rd_ain_a, .rd_ain_b);
  fan_monitor_config_regs uut (.clock, .rst_b, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .lock_set, .second_diode_cfg, .rd_diode, .rd_supply, .rd_ain_a, .rd_ain_b, .dem_input_a(v[0]),
    .dem_diode_two(v[1]), .dem_input_b(v[2]), .dem_diode_one(v[3]), .dem_onchip(v[4]), .fan_a_level(v[5]),
    .fan_b_level(v[6]), .min_level_a(v[7]), .min_level_b(v[8]), .spinup_level(v[9]), .max_level(v[10]),
    .cpu_hot_pin, .fan_a_on_src, .overtemp_src, .multipin_o, .multipin_oe, .cpu_hot_in, .speed_sample(),
    .cont_speed_meas_a, .cont_speed_meas_b, .input_a_resistor_sel, .input_b_resistor_sel,
    .one_channel_mode, .chan_sel, .meas_chan_code(), .fan_a_drive, .fan_b_drive);
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic ck(logic [7:0] g, logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    ck(reg_rdata, e);
    tick(1);
  endtask
  // second pass reverses the order of levels so every maximum changes winner
  task automatic setv(int p);
    for (int i = 0; i < 11; i++)
      v[i] = p ? 8'(8'h11 * (11 - i) + 4) : 8'(8'h11 * (i + 1));
  endtask
  function automatic logic [7:0] want(logic [7:0] c, logic [7:0] l, logic [7:0] mn, logic f);
    logic [7:0] m;
    m = 8'h00;
    if (c[0]) m = second_diode_cfg ? v[1] : v[0];
    if (c[1] && !second_diode_cfg && v[2] > m) m = v[2];
    if (c[2] && v[3] > m) m = v[3];
    if (c[3] && v[4] > m) m = v[4];
    if (c[4]) m = l;
    if (c[5]) m = mn;
    if (c[6]) m = v[9];
    if (c[7]) m = v[10];
    if (f && m < mn) m = mn;
    return m;
  endfunction
  task automatic drive(logic [7:0] c, logic f);
    wr(8'h03, {2'b00, f, f, 4'h0});
    wr(8'h05, c);
    wr(8'h06, c);
    tick(2);
    ck(fan_a_drive, want(c, v[5], v[7], f));
    ck(fan_b_drive, want(c, v[6], v[8], f));
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    setv(0);
    tick(2);
    rst_b = 1'b1;
    rd(8'h02, 8'hc0);
    rd(8'h03, 8'h00);
    rd(8'h05, 8'h0c);
    rd(8'h06, 8'h0c);
    rd(8'h04, 8'h00);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h3f);
    for (int c = 3; c < 6; c++) begin
      wr(8'h03, 8'h08 | 8'(c));
      rd(8'h03, 8'h08 | 8'(c));
      ck({4'h0, one_channel_mode, chan_sel}, 8'h08 | 8'(c));
    end
    wr(8'h02, 8'h40);
    ck({6'h00, input_a_resistor_sel, input_b_resistor_sel}, 8'h02);
    second_diode_cfg = 1'b1;
    tick(2);
    ck({6'h00, input_a_resistor_sel, input_b_resistor_sel}, 8'h00);
    second_diode_cfg = 1'b0;
    wr(8'h02, 8'h00);
    fan_a_on_src = 1'b1;
    tick(2);
    ck({6'h00, multipin_oe, multipin_o}, 8'h03);
    wr(8'h02, 8'h01);
    ck({6'h00, multipin_oe, multipin_o}, 8'h02);
    overtemp_src = 1'b1;
    tick(2);
    ck({6'h00, multipin_oe, multipin_o}, 8'h03);
    wr(8'h02, 8'h06);
    cpu_hot_pin = 1'b0;
    tick(5);
    ck({6'h00, multipin_oe, cpu_hot_in}, 8'h01);
    ck(fan_a_drive, 8'hff);
    ck(fan_b_drive, 8'hff);
    cpu_hot_pin = 1'b1;
    wr(8'h02, 8'hc0);
    for (int p = 0; p < 2; p++) begin
      setv(p);
      for (int k = 0; k < 10; k++)
        drive(cs[k], 1'b0);
      drive(8'h04, 1'b1);
    end
    second_diode_cfg = 1'b1;
    drive(8'h03, 1'b0);
    second_diode_cfg = 1'b0;
    s = '{rd_diode, rd_supply, rd_ain_b, rd_ain_a};
    tick(1);
    rd(8'h08, {s[3][1:0], s[2][1:0], s[1][1:0], s[0][1:0]});
    tick(3);
    for (int j = 0; j < 4; j++)
      rd(8'h0d - 8'(j), s[j][9:2]);
    clk_en = 1'b0;
    wr(8'h03, 8'h0b);
    clk_en = 1'b1;
    rd(8'h03, 8'h00);
    lock_set = 1'b1;
    wr(8'h02, 8'h3f);
    rd(8'h02, 8'hf0);
    ck({6'h00, cont_speed_meas_b, cont_speed_meas_a}, 8'h03);
    lock_set = 1'b0;
    wr(8'h02, 8'h0f);
    rd(8'h02, 8'hc0);
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    wr(8'h02, 8'h0f);
    rd(8'h02, 8'h0f);
    results();
  end
endmodule
